// File: inc/tfc_pkg.sv
// package: register map, reset values and carrier types of the trace capture block
package tfc_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] debug_control_off = 8'h00;
    localparam logic [7:0] trigger_select_off = 8'h04;
    localparam logic [7:0] debug_state_off = 8'h08;
    localparam logic [7:0] trace_count_off = 8'h0c;
    localparam logic [7:0] trace_high_off = 8'h10;
    localparam logic [7:0] trace_low_off = 8'h14;
    localparam logic [7:0] comp_a_ext_off = 8'h18;
    localparam logic [7:0] comp_a_high_off = 8'h1c;
    localparam logic [7:0] comp_a_low_off = 8'h20;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int module_enable_bit = 7;
    localparam int arm_bit = 6;
    localparam int break_enable_bit = 5;
    localparam int tag_bit = 4;
    localparam int opcode_qualify_bit = 7;
    localparam int begin_bit = 6;
    localparam int armed_flag_bit = 7;
    localparam int trig_seen_bit = 6;

    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam logic [7:0] control_reset = 8'hc0;
    localparam logic [7:0] trigger_reset = 8'h40;
    localparam logic [7:0] comp_a_ext_reset = 8'h00;
    localparam logic [7:0] comp_a_high_reset = 8'hff;
    localparam logic [7:0] comp_a_low_reset = 8'hfe;
    localparam int fifo_depth = 8;
    localparam logic [3:0] fifo_full_count = 4'h8;
    localparam logic [15:0] branch_back = 16'h0002;

    typedef enum logic [3:0] {
        mode_a_only,
        mode_a_or_b,
        mode_a_then_b,
        mode_event_b,
        mode_a_then_event_b,
        mode_a_and_b,
        mode_a_not_b,
        mode_inside,
        mode_outside
    } tfc_mode_type;

    // core-side signals sampled each bus clock
    typedef struct packed {
        logic [1:0] cof;
        logic [15:0] addr;
        logic [15:0] opcode_addr;
        logic [7:0] data;
        logic trig_event;
        logic irq_pending;
    } tfc_core_type;
endpackage

// File: core/tfc_capture.sv
// trace capture buffer with AHB-Lite register access
//
// Operation
// R1: eight entries, change-of-flow addresses normally
// R2: event-only stores data value, high byte zero
// R3: destination indicator stores current core address
// R4: branch indicator stores previous address minus two
// R5: begin trigger stores after trigger until eight
// R6: end trigger stores until trigger then disarms
// R7: end trigger stores trigger change of flow
// R8: readout only enabled and disarmed, oldest first
// R9: count shows valid entries, no decrement
// R10: low byte read shifts to next entry
// R11: event-only host reads low byte only
// R12: armed read returns oldest, no shift
// R13: disarmed low read captures opcode address
// R14: opcode qualify plus pending interrupt blocks trigger
// R15: fetch trigger, end mode, still disarms
// R16: fetch trigger, begin mode, captures, stays armed
// R17: never requests a microcontroller reset
// R18: end trace reset clears arm and break
// R19: other resets load comparator a vector
// R20: default reset enables, arms, begin a-only
// R21: end trigger keeps most recent eight
// R22: count increments and saturates at eight
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tfc_capture (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire tfc_pkg::tfc_core_type core_in,
    input wire logic sys_reset,
    output logic cpu_break,
    output logic reset_request
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] debug_control_reg;
    logic [7:0] trigger_select_reg;
    logic [7:0] comp_a_extension;
    logic [7:0] comp_a_high;
    logic [7:0] comp_a_low;
    logic armed_flag;
    logic trig_seen;
    logic [3:0] valid_entry_count;
    logic [15:0] fifo_mem [tfc_pkg::fifo_depth];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [15:0] prev_addr;
    logic wr_pend;
    logic [7:0] wr_addr;

    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction

    // ----------------------------------------------------------------
    // decode of the current mode
    // ----------------------------------------------------------------
    logic module_enable;
    logic arm_ctrl;
    logic break_enable;
    logic opcode_qualify_select;
    logic event_only;
    logic begin_mode;
    logic trig_ok;
    logic addr_phase;
    logic low_read;
    logic push;
    logic [15:0] push_data;
    logic fifo_filled;
    logic end_keep;
    logic arm_go;

    assign module_enable = debug_control_reg[tfc_pkg::module_enable_bit];
    assign arm_ctrl = debug_control_reg[tfc_pkg::arm_bit];
    assign break_enable = debug_control_reg[tfc_pkg::break_enable_bit];
    assign opcode_qualify_select = trigger_select_reg[tfc_pkg::opcode_qualify_bit];
    assign event_only = (trigger_select_reg[3:0] == tfc_pkg::mode_event_b)
        || (trigger_select_reg[3:0] == tfc_pkg::mode_a_then_event_b);
    // event-only modes count as begin type whatever the begin bit says
    assign begin_mode = trigger_select_reg[tfc_pkg::begin_bit] || event_only;
    // interrupt wins over a qualified opcode reaching the pipe top
    assign trig_ok = core_in.trig_event
        && !(opcode_qualify_select && core_in.irq_pending); // R14 R15 R16
    assign end_keep = module_enable && !begin_mode; // R18

    assign addr_phase = hsel && htrans[1] && hready;
    assign low_read = addr_phase && !hwrite && hit(haddr, tfc_pkg::trace_low_off);
    assign arm_go = wr_pend && (wr_addr == tfc_pkg::debug_control_off)
        && hwdata[tfc_pkg::module_enable_bit] && hwdata[tfc_pkg::arm_bit] && !armed_flag;

    // ----------------------------------------------------------------
    // store decision
    // ----------------------------------------------------------------
    always_comb begin
        push = 1'b0;
        push_data = 16'h0000;
        if (armed_flag) begin
            if (event_only) begin
                push = trig_ok; // R2
                push_data = {8'h00, core_in.data}; // R2
            end else if (begin_mode) begin
                push = (trig_seen || trig_ok) && (core_in.cof != 2'b00); // R5 R16
            end else begin
                // trigger cycle change of flow is still kept
                push = core_in.cof != 2'b00; // R6 R7
            end
            if (!event_only) begin
                if (core_in.cof[1]) begin
                    push_data = core_in.addr; // R1 R3
                end else begin
                    push_data = prev_addr - tfc_pkg::branch_back; // R4
                end
            end
        end else if (module_enable && low_read) begin
            push = 1'b1; // R13
            push_data = core_in.opcode_addr; // R13
        end
    end

    assign fifo_filled = push && begin_mode && armed_flag
        && (valid_entry_count == tfc_pkg::fifo_full_count - 4'h1);

    // ----------------------------------------------------------------
    // control, arming and the two reset flavours
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            debug_control_reg <= tfc_pkg::control_reset; // R20
            trigger_select_reg <= tfc_pkg::trigger_reset; // R20
            comp_a_extension <= tfc_pkg::comp_a_ext_reset; // R19
            comp_a_high <= tfc_pkg::comp_a_high_reset; // R19
            comp_a_low <= tfc_pkg::comp_a_low_reset; // R19
            armed_flag <= 1'b1;
            trig_seen <= 1'b0;
        end else if (sys_reset) begin
            if (end_keep) begin
                // trace results stay readable across the reset
                debug_control_reg[tfc_pkg::arm_bit] <= 1'b0; // R18
                debug_control_reg[tfc_pkg::break_enable_bit] <= 1'b0; // R18
                armed_flag <= 1'b0; // R18
            end else begin
                debug_control_reg <= tfc_pkg::control_reset; // R20
                trigger_select_reg <= tfc_pkg::trigger_reset; // R20
                comp_a_extension <= tfc_pkg::comp_a_ext_reset; // R19
                comp_a_high <= tfc_pkg::comp_a_high_reset; // R19
                comp_a_low <= tfc_pkg::comp_a_low_reset; // R19
                armed_flag <= 1'b1;
                trig_seen <= 1'b0;
            end
        end else if (wr_pend) begin
            case (wr_addr)
                tfc_pkg::debug_control_off: begin
                    debug_control_reg <= hwdata[7:0];
                    armed_flag <= hwdata[tfc_pkg::module_enable_bit]
                        && hwdata[tfc_pkg::arm_bit];
                    if (arm_go) begin
                        trig_seen <= 1'b0;
                    end
                end
                tfc_pkg::trigger_select_off: trigger_select_reg <= hwdata[7:0];
                tfc_pkg::comp_a_ext_off: comp_a_extension <= hwdata[7:0];
                tfc_pkg::comp_a_high_off: comp_a_high <= hwdata[7:0];
                tfc_pkg::comp_a_low_off: comp_a_low <= hwdata[7:0];
                default: begin
                end
            endcase
        end else if (armed_flag) begin
            if (!module_enable || !arm_ctrl) begin
                armed_flag <= 1'b0;
            end else if (!begin_mode && trig_ok) begin
                debug_control_reg[tfc_pkg::arm_bit] <= 1'b0; // R6 R15
                armed_flag <= 1'b0; // R6 R15
            end else if (fifo_filled) begin
                debug_control_reg[tfc_pkg::arm_bit] <= 1'b0; // R5
                armed_flag <= 1'b0; // R5
            end
            if (begin_mode && trig_ok) begin
                trig_seen <= 1'b1; // R5
            end
        end
    end

    // ----------------------------------------------------------------
    // eight entry ring
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            valid_entry_count <= 4'h0;
        end else if (arm_go) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            valid_entry_count <= 4'h0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 3'h1; // R1
                if (valid_entry_count != tfc_pkg::fifo_full_count) begin
                    valid_entry_count <= valid_entry_count + 4'h1; // R22 R9
                end
            end
            // a full ring drops its oldest entry to make room
            if (push && valid_entry_count == tfc_pkg::fifo_full_count
                    && wr_ptr == rd_ptr) begin
                rd_ptr <= rd_ptr + 3'h1; // R21
            end else if (low_read && module_enable && !armed_flag && !arm_ctrl) begin
                rd_ptr <= rd_ptr + 3'h1; // R8 R10 R12
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= push_data; // R1
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_addr <= 16'h0000;
        end else begin
            prev_addr <= core_in.addr; // R4
        end
    end

    // ----------------------------------------------------------------
    // break and reset outputs
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_break <= 1'b0;
        end else begin
            cpu_break <= armed_flag && break_enable && !sys_reset && !wr_pend
                && (fifo_filled || (!begin_mode && trig_ok));
        end
    end

    assign reset_request = 1'b0; // R17

    // ----------------------------------------------------------------
    // AHB-Lite slave, zero wait, read data registered in address phase
    // ----------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            wr_pend <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
            wr_addr <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                // high byte never shifts so it may be read first
                if (hit(haddr, tfc_pkg::debug_control_off)) begin
                    hrdata <= {24'h000000, debug_control_reg};
                end else if (hit(haddr, tfc_pkg::trigger_select_off)) begin
                    hrdata <= {24'h000000, trigger_select_reg};
                end else if (hit(haddr, tfc_pkg::debug_state_off)) begin
                    hrdata <= {24'h000000, armed_flag, trig_seen, 6'h00};
                end else if (hit(haddr, tfc_pkg::trace_count_off)) begin
                    hrdata <= {28'h0000000, valid_entry_count}; // R9
                end else if (hit(haddr, tfc_pkg::trace_high_off)) begin
                    hrdata <= {24'h000000, fifo_mem[rd_ptr][15:8]}; // R8 R10
                end else if (hit(haddr, tfc_pkg::trace_low_off)) begin
                    hrdata <= {24'h000000, fifo_mem[rd_ptr][7:0]}; // R8 R11 R12
                end else if (hit(haddr, tfc_pkg::comp_a_ext_off)) begin
                    hrdata <= {24'h000000, comp_a_extension};
                end else if (hit(haddr, tfc_pkg::comp_a_high_off)) begin
                    hrdata <= {24'h000000, comp_a_high};
                end else if (hit(haddr, tfc_pkg::comp_a_low_off)) begin
                    hrdata <= {24'h000000, comp_a_low};
                end else begin
                    hrdata <= 32'h00000000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_count_saturates: assert property (valid_entry_count <= tfc_pkg::fifo_full_count) // R22
        else $error("entry count above eight");

    a_armed_read_holds: assert property ((low_read && armed_flag && !arm_go) // R12
        |=> $stable(rd_ptr) || $past(push))
        else $error("armed read shifted the buffer");

    a_disarmed_read_shifts: assert property ((low_read && module_enable // R10
        && !armed_flag && !arm_ctrl && !arm_go) |=> rd_ptr == $past(rd_ptr) + 3'h1)
        else $error("disarmed low read did not shift");

    a_count_no_decrement: assert property ((!arm_go && !sys_reset) // R9
        |=> valid_entry_count >= $past(valid_entry_count))
        else $error("count decremented");

    a_end_trigger_disarm: assert property ((armed_flag && arm_ctrl && module_enable // R6
        && !begin_mode && trig_ok && !wr_pend && !sys_reset)
        |=> !armed_flag && !arm_ctrl)
        else $error("end trigger did not disarm");

    a_begin_fill_disarm: assert property ((fifo_filled && arm_ctrl && module_enable // R5
        && !wr_pend && !sys_reset) |=> !armed_flag ##1 !armed_flag)
        else $error("begin run still armed after eight entries");

    a_begin_waits: assert property ((armed_flag && begin_mode && !event_only // R5
        && !trig_seen && !trig_ok) |-> !push)
        else $error("begin run stored before trigger");

    a_event_high_zero: assert property ((push && armed_flag && event_only) // R2
        |-> push_data[15:8] == 8'h00)
        else $error("event entry high byte not zero");

    a_dest_address: assert property ((push && armed_flag && !event_only // R3
        && core_in.cof[1]) |-> push_data == core_in.addr)
        else $error("destination address not stored");

    a_branch_source: assert property ((push && armed_flag && !event_only // R4
        && core_in.cof == 2'b01) |-> push_data == $past(core_in.addr) - 16'h0002)
        else $error("branch source address wrong");

    a_profile_capture: assert property ((low_read && module_enable && !armed_flag) // R13
        |-> push && push_data == core_in.opcode_addr)
        else $error("profile read did not capture");

    a_irq_blocks_trigger: assert property ((armed_flag && arm_ctrl && module_enable // R14
        && opcode_qualify_select && core_in.irq_pending && !trig_seen && !wr_pend
        && !sys_reset) |=> armed_flag && !trig_seen
        && (valid_entry_count == $past(valid_entry_count) || !$past(begin_mode)))
        else $error("qualified trigger taken over pending interrupt");

    a_no_reset_request: assert property (reset_request == 1'b0) // R17
        else $error("reset requested");

    a_default_reset: assert property ((sys_reset && !end_keep) // R19 R20
        |=> debug_control_reg == 8'hc0 && trigger_select_reg == 8'h40
        && comp_a_low == 8'hfe && comp_a_high == 8'hff)
        else $error("default reset values wrong");

    a_end_reset_keep: assert property ((sys_reset && end_keep) // R18
        |=> !armed_flag && !arm_ctrl && !break_enable
        && trigger_select_reg == $past(trigger_select_reg))
        else $error("end trace reset lost state");

    // main scenarios reached
    c_end_run: cover property (armed_flag && !begin_mode ##1 !armed_flag);
    c_begin_full: cover property (fifo_filled);
    c_wrap: cover property (push && valid_entry_count == tfc_pkg::fifo_full_count);
    c_profile: cover property (low_read && module_enable && !armed_flag);
    c_irq_blocked: cover property (armed_flag && opcode_qualify_select && core_in.irq_pending);
endmodule
`default_nettype wire

// File: verification/tfc_core_model.sv
// partner model: cpu core side driving change-of-flow, address and data lines
`timescale 1ns/1ns
`default_nettype none
module tfc_core_model (
    input wire logic hclk,
    output var tfc_pkg::tfc_core_type core_out
);
    // ----------------------------------------------------------------
    // one value per call, each field standing until a later call changes it
    // ----------------------------------------------------------------
    initial core_out = '0;

    task automatic step(input tfc_pkg::tfc_core_type v);
        @(posedge hclk);
        core_out <= v;
    endtask

    // ----------------------------------------------------------------
    // idle: no flow change, but address and data keep moving
    // so that a stale latch in the design never reads as a match
    // ----------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge hclk);
            core_out.cof <= 2'h0;
            core_out.trig_event <= 1'b0;
            core_out.irq_pending <= 1'b0;
            core_out.addr <= core_out.addr + 16'h0111;
            core_out.data <= ~core_out.data;
        end
    endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// testbench: register defaults, begin, end and event-only runs, readout
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [7:0] off;
        logic [7:0] exp;
        logic [7:0] mask;
    } tfc_row_type;

    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [2:0] hsize;
    logic sys_reset;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic cpu_break;
    logic reset_request;
    wire tfc_pkg::tfc_core_type core_in;
    int num_errors = 0;
    int checks_done = 0;
    int breaks = 0;
    int i;
    logic [31:0] v;
    logic [15:0] a;
    logic [15:0] prev;
    logic [7:0] d;
    logic [1:0] c;
    logic [15:0] expq[$];
    // state mask: trigger-seen bit is not part of the reset picture
    tfc_row_type rows [8] = '{
        '{tfc_pkg::debug_control_off, 8'hc0, 8'hff},
        '{tfc_pkg::trigger_select_off, 8'h40, 8'hff},
        '{tfc_pkg::debug_state_off, 8'h80, 8'h80},
        '{tfc_pkg::trace_count_off, 8'h00, 8'h0f},
        '{tfc_pkg::comp_a_ext_off, 8'h00, 8'hff},
        '{tfc_pkg::comp_a_high_off, 8'hff, 8'hff},
        '{tfc_pkg::comp_a_low_off, 8'hfe, 8'hff},
        '{8'h40, 8'h00, 8'hff}
    };

    tfc_capture i_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .core_in(core_in),
        .sys_reset(sys_reset),
        .cpu_break(cpu_break),
        .reset_request(reset_request)
    );

    tfc_core_model i_core (
        .hclk(hclk),
        .core_out(core_in)
    );

    always #5 hclk = ~hclk;

    always @(posedge hclk) begin
        if (cpu_break === 1'b1) begin
            breaks++;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                num_errors++;
                end_sim();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] off, input logic [7:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, off};
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rd(input logic [7:0] off);
        bus(1'b0, off, 8'h00, v);
    endtask

    task automatic wr(input logic [7:0] off, input logic [7:0] wd);
        logic [31:0] unused;
        bus(1'b1, off, wd, unused);
    endtask

    function automatic tfc_pkg::tfc_core_type cv(input logic [1:0] cf, input logic [15:0] ad,
                                                 input logic [7:0] dt, input logic t,
                                                 input logic irq);
        cv = {cf, ad, ~ad, dt, t, irq};
    endfunction

    // the other reset leaves the ring and its count alone
    task automatic check_defaults(input logic [3:0] cnt);
        foreach (rows[k]) begin
            rd(rows[k].off);
            check(v & {24'h0, rows[k].mask}, {24'h0, (rows[k].off == tfc_pkg::trace_count_off)
                ? {4'h0, cnt} : rows[k].exp});
        end
    endtask

    task automatic pulse_sys_reset;
        sys_reset <= 1'b1;
        @(posedge hclk);
        sys_reset <= 1'b0;
        @(posedge hclk);
    endtask

    // high byte optional, low byte read shifts to the next entry
    task automatic readout(input int n, input logic hi);
        for (int k = 0; k < n; k++) begin
            if (hi) begin
                rd(tfc_pkg::trace_high_off);
                check(v, {24'h0, expq[k][15:8]});
            end
            rd(tfc_pkg::trace_low_off);
            check(v, {24'h0, expq[k][7:0]});
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        sys_reset = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check_defaults(4'h0);
        check({31'h0, reset_request}, 32'h0);
        $display("test reset_defaults done");

        // begin run: nothing before trigger, then eight entries
        wr(tfc_pkg::trigger_select_off, 8'h40);
        wr(tfc_pkg::debug_control_off, 8'he0);
        i_core.step(cv(2'h2, 16'h0f00, 8'h00, 1'b0, 1'b0));
        a = 16'h1000;
        prev = a;
        i_core.step(cv(2'h2, a, 8'h00, 1'b1, 1'b0));
        expq.push_back(a);
        for (i = 1; i < 8; i++) begin
            a = a + 16'h0110;
            c = i[0] ? 2'h1 : 2'h2;
            i_core.step(cv(c, a, 8'h00, 1'b0, 1'b0));
            expq.push_back(c[0] ? prev - 16'h0002 : a);
            prev = a;
        end
        i_core.idle(2);
        i_core.step(cv(2'h2, 16'h3333, 8'h00, 1'b0, 1'b0));
        i_core.idle(4);
        check(32'(breaks), 32'h1);
        rd(tfc_pkg::debug_state_off);
        check(v & 32'h80, 32'h0);
        rd(tfc_pkg::trace_count_off);
        check(v, 32'h8);
        readout(8, 1'b1);
        rd(tfc_pkg::trace_count_off);
        check(v, 32'h8);
        rd(tfc_pkg::trace_low_off);
        check(v, 32'hcc);
        $display("test begin_run done");

        // end run: ten entries, armed reads, trigger entry, end-trace reset
        expq.delete();
        wr(tfc_pkg::trigger_select_off, 8'h00);
        wr(tfc_pkg::debug_control_off, 8'he0);
        a = 16'h2000;
        for (i = 0; i < 10; i++) begin
            i_core.step(cv(2'h2, a, 8'h00, 1'b0, 1'b0));
            if (i >= 3) begin
                expq.push_back(a);
            end
            a = a + 16'h0001;
        end
        i_core.idle(1);
        repeat (2) begin
            rd(tfc_pkg::trace_low_off);
            check(v, 32'h02);
        end
        i_core.step(cv(2'h2, 16'h20ff, 8'h00, 1'b1, 1'b0));
        expq.push_back(16'h20ff);
        i_core.step(cv(2'h2, 16'h2abc, 8'h00, 1'b0, 1'b0));
        i_core.idle(3);
        check(32'(breaks), 32'h2);
        pulse_sys_reset();
        rd(tfc_pkg::debug_control_off);
        check(v, 32'h80);
        rd(tfc_pkg::trigger_select_off);
        check(v, 32'h0);
        rd(tfc_pkg::debug_state_off);
        check(v & 32'h80, 32'h0);
        rd(tfc_pkg::trace_count_off);
        check(v, 32'h8);
        readout(8, 1'b0);
        $display("test end_run done");

        // other reset reloads the default begin run
        wr(tfc_pkg::comp_a_high_off, 8'h12);
        rd(tfc_pkg::comp_a_high_off);
        check(v, 32'h12);
        wr(tfc_pkg::trigger_select_off, 8'h40);
        pulse_sys_reset();
        check_defaults(4'h8);
        $display("test default_reset done");

        // event-only with opcode qualify: pending interrupt blocks trigger
        expq.delete();
        wr(tfc_pkg::debug_control_off, 8'h80);
        wr(tfc_pkg::trigger_select_off, 8'h83);
        wr(tfc_pkg::debug_control_off, 8'hc0);
        i_core.step(cv(2'h0, 16'h4000, 8'hee, 1'b1, 1'b1));
        d = 8'h10;
        for (i = 0; i < 8; i++) begin
            i_core.step(cv(2'h0, 16'h4100, d, 1'b1, 1'b0));
            expq.push_back({8'h00, d});
            d = d + 8'h01;
        end
        i_core.idle(3);
        rd(tfc_pkg::trace_count_off);
        check(v, 32'h8);
        readout(8, 1'b1);
        check({31'h0, hresp}, 32'h0);
        check({31'h0, reset_request}, 32'h0);
        $display("test event_only done");
        end_sim();
    end
endmodule
`default_nettype wire
